// ===== spmc_ctrl.sv
// SPI master/slave controller with system bus register port and receive buffer
// Functional notes
// - Master clock equals bus clock over divider
// - Bit order selectable, LSB or MSB first
// - Polarity bit moves leading edges to falling
// - Phase bit selects alternate clock-data relation
// - Handshake extension marks unready slave read data
// - Up to four selects, register enables each
// - Transmit-ready flag on empty, write-one clears
// - Receive-ready flag on new data, write-one clears
// - Mode fault when select low in master
// - Overrun flag when byte arrives with receive buffer full
// - Wakeup driven only with wakeup enable set
// - Interrupt request on enabled interrupt condition
// - Serial clock output master, input slave
// - MOSI driven as master, received as slave
// - MISO received as master, driven as slave
// - Four active-low master chip select outputs
// - 8-bit address, separate 8-bit data paths
// - Acknowledge answers each strobed transaction
// - Master-select bit picks master or slave
`timescale 1ns/1ps

module spmc_rx_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Pointers wrap naturally, so DEPTH must be a power of two
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // spmc_rx_buffer

module spmc_ctrl #(
   parameter int RX_DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bus_strobe_in,
   input wire logic bus_write_not_read,
   input wire logic [7:0] bus_register_address,
   input wire logic [7:0] bus_write_data,
   output logic [7:0] bus_read_data,
   output logic bus_acknowledge_out,
   output logic interrupt_request_out,
   output logic wakeup_out,
   input wire logic received_serial_clock,
   output logic serial_clock_out,
   output logic serial_clock_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic slave_select_in_n,
   output logic [3:0] master_selects_out_n
);
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction
   function automatic logic head_of(input logic [7:0] data, input logic lsb_first);
      return lsb_first ? data[0] : data[7];
   endfunction
   logic [7:0] control_register_one;
   logic [7:0] control_register_two;
   logic [7:0] clock_divider;
   logic [7:0] chip_select_control;
   logic [3:0] interrupt_enables;
   logic [3:0] interrupt_flags;
   logic [7:0] transmit_data_register;
   logic tx_full;
   spmc_pkg::spmc_state_t state;
   logic [7:0] shreg;
   logic [3:0] bcnt;
   logic [7:0] dcnt;
   logic sck_s1, sck_s2, sck_s3;
   logic ss_s1, ss_s2;
   logic mosi_s1, mosi_s2;
   // Bus decode: one acknowledge per strobe, the next cycle
   wire bus_req = bus_strobe_in & ~bus_acknowledge_out;
   wire bus_wr = bus_req & bus_write_not_read;
   wire bus_rd = bus_req & ~bus_write_not_read;
   wire master_select_bit = control_register_two[spmc_pkg::MASTER_SELECT_BIT];
   wire slave_read_handshake_enable = control_register_two[spmc_pkg::HANDSHAKE_ENABLE_BIT];
   wire cpol = control_register_two[spmc_pkg::CLOCK_POLARITY_BIT];
   wire cpha = control_register_two[spmc_pkg::CLOCK_PHASE_BIT];
   wire bit_order_select = control_register_two[spmc_pkg::BIT_ORDER_BIT];
   wire wakeup_enable_bit = control_register_one[spmc_pkg::WAKEUP_ENABLE_BIT];
   wire rx_in_ready;
   wire rx_out_valid;
   wire [7:0] receive_data_register;
   wire rx_pop = bus_rd & hit(bus_register_address, spmc_pkg::ADDR_RX_DATA);
   wire st_idle = (state == spmc_pkg::ST_IDLE);
   wire st_master = (state == spmc_pkg::ST_MASTER);
   wire st_slave = (state == spmc_pkg::ST_SLAVE);
   wire ss_low = ~ss_s2;
   // Divider below two cannot make both clock phases
   wire [7:0] div_eff = (clock_divider < spmc_pkg::CLK_DIV_MIN) ? spmc_pkg::CLK_DIV_MIN : clock_divider;
   wire [7:0] div_half = div_eff >> 1;
   wire m_lead = st_master & (dcnt == div_half - 8'h01);
   wire m_trail = st_master & (dcnt == div_eff - 8'h01);
   // Leading edge leaves the idle level, which is high when polarity is set
   wire s_lead = st_slave & ((sck_s2 ^ cpol) & ~(sck_s3 ^ cpol));
   wire s_trail = st_slave & (~(sck_s2 ^ cpol) & (sck_s3 ^ cpol));
   wire lead = m_lead | s_lead;
   wire trail = m_trail | s_trail;
   wire sample = cpha ? trail : lead;
   wire drive = cpha ? lead : trail;
   wire in_bit = st_master ? miso_in : mosi_s2;
   wire [7:0] shifted = bit_order_select ? {in_bit, shreg[7:1]} : {shreg[6:0], in_bit};
   wire [3:0] next_bcnt = bcnt + {3'h0, sample};
   wire byte_done = sample & (next_bcnt == spmc_pkg::BITS_PER_BYTE);
   wire m_end = m_trail & (next_bcnt == spmc_pkg::BITS_PER_BYTE);
   // Master stalls when the receive buffer is full, so no master byte is lost
   wire ss_high_ok = ~ss_low;
   wire m_start = st_idle & master_select_bit & ss_high_ok & tx_full & rx_in_ready;
   wire s_start = st_idle & ~master_select_bit & ss_low;
   wire mode_fault_event = master_select_bit & ss_low;
   // Without loaded data the handshake byte tells the far master to retry
   wire [7:0] slave_fill = tx_full ? transmit_data_register :
      (slave_read_handshake_enable ? spmc_pkg::HANDSHAKE_WAIT_BYTE : spmc_pkg::SLAVE_IDLE_BYTE);
   wire s_reload = st_slave & byte_done & ss_low;
   wire load_tx = m_start | ((s_start | s_reload) & tx_full);
   wire rx_push = byte_done;
   wire overrun_event = byte_done & ~rx_in_ready;
   wire [3:0] irq_events;
   assign irq_events[spmc_pkg::FLAG_TX_READY] = load_tx;
   assign irq_events[spmc_pkg::FLAG_RX_READY] = rx_push & rx_in_ready;
   assign irq_events[spmc_pkg::FLAG_MODE_FAULT] = mode_fault_event;
   assign irq_events[spmc_pkg::FLAG_RX_OVERRUN] = overrun_event;
   wire flag_clear_wr = bus_wr & hit(bus_register_address, spmc_pkg::ADDR_IRQ_FLAGS);
   wire [3:0] flag_clear = flag_clear_wr ? bus_write_data[3:0] : 4'h0;
   // A new event in the clearing cycle survives the clear
   wire [3:0] next_interrupt_flags = (interrupt_flags & ~flag_clear) | irq_events;
   wire [7:0] status_value = {4'h0, interrupt_flags[spmc_pkg::FLAG_RX_OVERRUN],
      interrupt_flags[spmc_pkg::FLAG_MODE_FAULT], rx_out_valid, ~tx_full};
   wire [7:0] next_read_data =
      hit(bus_register_address, spmc_pkg::ADDR_CTRL_ONE) ? control_register_one :
      hit(bus_register_address, spmc_pkg::ADDR_CTRL_TWO) ? control_register_two :
      hit(bus_register_address, spmc_pkg::ADDR_CLK_DIV) ? clock_divider :
      hit(bus_register_address, spmc_pkg::ADDR_CS_CTRL) ? chip_select_control :
      hit(bus_register_address, spmc_pkg::ADDR_STATUS) ? status_value :
      hit(bus_register_address, spmc_pkg::ADDR_TX_DATA) ? transmit_data_register :
      hit(bus_register_address, spmc_pkg::ADDR_RX_DATA) ? receive_data_register :
      hit(bus_register_address, spmc_pkg::ADDR_IRQ_FLAGS) ? {4'h0, interrupt_flags} :
      hit(bus_register_address, spmc_pkg::ADDR_IRQ_EN) ? {4'h0, interrupt_enables} :
      spmc_pkg::ADDR_UNMAPPED_DATA;
   spmc_rx_buffer #(
      .WIDTH(8),
      .DEPTH(RX_DEPTH)
   ) u_rx_buffer (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(shifted),
      .out_valid(rx_out_valid),
      .out_ready(rx_pop),
      .out_data(receive_data_register)
   );
   // Bus slave and software-visible registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_acknowledge_out <= 1'b0;
         bus_read_data <= 8'h00;
         control_register_one <= spmc_pkg::CTRL_ONE_RESET;
         control_register_two <= spmc_pkg::CTRL_TWO_RESET;
         clock_divider <= spmc_pkg::CLK_DIV_RESET;
         chip_select_control <= spmc_pkg::CS_CTRL_RESET;
         interrupt_enables <= spmc_pkg::IRQ_EN_RESET;
         interrupt_flags <= 4'h0;
         transmit_data_register <= 8'h00;
         tx_full <= 1'b0;
         interrupt_request_out <= 1'b0;
      end else begin
         bus_acknowledge_out <= bus_req;
         if (bus_rd) begin
            bus_read_data <= next_read_data;
         end
         if (bus_wr) begin
            if (hit(bus_register_address, spmc_pkg::ADDR_CTRL_ONE)) begin
               control_register_one <= bus_write_data;
            end
            if (hit(bus_register_address, spmc_pkg::ADDR_CTRL_TWO)) begin
               control_register_two <= bus_write_data;
            end
            if (hit(bus_register_address, spmc_pkg::ADDR_CLK_DIV)) begin
               clock_divider <= bus_write_data;
            end
            if (hit(bus_register_address, spmc_pkg::ADDR_CS_CTRL)) begin
               chip_select_control <= bus_write_data;
            end
            if (hit(bus_register_address, spmc_pkg::ADDR_IRQ_EN)) begin
               interrupt_enables <= bus_write_data[3:0];
            end
         end
         // A write to a full transmit register is dropped
         if (bus_wr && hit(bus_register_address, spmc_pkg::ADDR_TX_DATA) && !tx_full) begin
            transmit_data_register <= bus_write_data;
            tx_full <= 1'b1;
         end else if (load_tx) begin
            tx_full <= 1'b0;
         end
         interrupt_flags <= next_interrupt_flags;
         interrupt_request_out <= |(interrupt_flags & interrupt_enables);
      end
   end
   // Serial pin synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end else begin
         sck_s1 <= received_serial_clock;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         ss_s1 <= slave_select_in_n;
         ss_s2 <= ss_s1;
         mosi_s1 <= mosi_in;
         mosi_s2 <= mosi_s1;
      end
   end
   // Shift engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= spmc_pkg::ST_IDLE;
         shreg <= 8'h00;
         bcnt <= 4'h0;
         dcnt <= 8'h00;
         serial_clock_out <= 1'b0;
         mosi_out <= 1'b0;
         miso_out <= 1'b0;
         wakeup_out <= 1'b0;
      end else begin
         wakeup_out <= wakeup_enable_bit & s_start;
         case (state)
            spmc_pkg::ST_IDLE: begin
               serial_clock_out <= cpol;
               dcnt <= 8'h00;
               bcnt <= 4'h0;
               if (m_start) begin
                  state <= spmc_pkg::ST_MASTER;
                  shreg <= transmit_data_register;
                  mosi_out <= head_of(transmit_data_register, bit_order_select);
               end else if (s_start) begin
                  state <= spmc_pkg::ST_SLAVE;
                  shreg <= slave_fill;
                  miso_out <= head_of(slave_fill, bit_order_select);
               end
            end
            spmc_pkg::ST_MASTER: begin
               dcnt <= m_trail ? 8'h00 : dcnt + 8'h01;
               if (lead) begin
                  serial_clock_out <= ~cpol;
               end else if (trail) begin
                  serial_clock_out <= cpol;
               end
               if (sample) begin
                  shreg <= shifted;
                  bcnt <= next_bcnt;
               end
               if (drive) begin
                  mosi_out <= head_of(shreg, bit_order_select);
               end
               if (mode_fault_event || m_end) begin
                  state <= spmc_pkg::ST_IDLE;
               end
            end
            spmc_pkg::ST_SLAVE: begin
               if (!ss_low || master_select_bit) begin
                  state <= spmc_pkg::ST_IDLE;
               end else if (s_reload) begin
                  shreg <= slave_fill;
                  bcnt <= 4'h0;
               end else if (sample) begin
                  shreg <= shifted;
                  bcnt <= next_bcnt;
               end
               if (drive && !s_reload) begin
                  miso_out <= head_of(shreg, bit_order_select);
               end
            end
            default: begin
               state <= spmc_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // Pin direction and master chip selects
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_clock_oe <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         serial_clock_oe <= master_select_bit;
         mosi_oe <= master_select_bit;
         miso_oe <= ~master_select_bit & ss_low;
      end
   end
   for (genvar i = 0; i < spmc_pkg::NUM_SELECTS; i++) begin : g_select
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            master_selects_out_n[i] <= 1'b1;
         end else begin
            master_selects_out_n[i] <= ~(master_select_bit & chip_select_control[spmc_pkg::CS_ENABLE_LSB + i]
               & chip_select_control[spmc_pkg::CS_ASSERT_LSB + i]);
         end
      end
   end
endmodule // spmc_ctrl

// ===== spmc_pkg.sv
// Constants, register map and state encoding for the SPI master/slave controller
package spmc_pkg;
   // Register addresses on the 8-bit system bus
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h08;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h09;
   localparam logic [7:0] ADDR_CLK_DIV = 8'h0a;
   localparam logic [7:0] ADDR_CS_CTRL = 8'h0b;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_TX_DATA = 8'h0d;
   localparam logic [7:0] ADDR_RX_DATA = 8'h0e;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h06;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h07;
   localparam logic [7:0] ADDR_UNMAPPED_DATA = 8'h00;

   // control_register_one fields
   localparam int WAKEUP_ENABLE_BIT = 7;
   // control_register_two fields
   localparam int MASTER_SELECT_BIT = 7;
   localparam int HANDSHAKE_ENABLE_BIT = 6;
   localparam int CLOCK_POLARITY_BIT = 2;
   localparam int CLOCK_PHASE_BIT = 1;
   localparam int BIT_ORDER_BIT = 0;
   // chip_select_control: upper nibble brings a select out, lower nibble asserts it
   localparam int CS_ENABLE_LSB = 4;
   localparam int CS_ASSERT_LSB = 0;
   localparam int NUM_SELECTS = 4;
   // Interrupt flag / enable / status positions
   localparam int FLAG_TX_READY = 0;
   localparam int FLAG_RX_READY = 1;
   localparam int FLAG_MODE_FAULT = 2;
   localparam int FLAG_RX_OVERRUN = 3;
   localparam int NUM_FLAGS = 4;

   // Reset values: slave mode, divide by two, all selects brought out and idle
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam logic [7:0] CLK_DIV_RESET = 8'h02;
   localparam logic [7:0] CLK_DIV_MIN = 8'h02;
   localparam logic [7:0] CS_CTRL_RESET = 8'hf0;
   localparam logic [3:0] IRQ_EN_RESET = 4'h0;

   // Bytes a slave sends when software has not loaded the transmit register
   localparam logic [7:0] SLAVE_IDLE_BYTE = 8'hff;
   localparam logic [7:0] HANDSHAKE_WAIT_BYTE = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MASTER = 3'b010,
      ST_SLAVE = 3'b100
   } spmc_state_t;
endpackage

// ===== spmc_ctrl_chk.sv
// Port-level assertions for the SPI controller
`timescale 1ns/1ps
module spmc_ctrl_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bus_strobe_in,
   input wire logic bus_write_not_read,
   input wire logic [7:0] bus_read_data,
   input wire logic bus_acknowledge_out,
   input wire logic wakeup_out,
   input wire logic serial_clock_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic slave_select_in_n,
   input wire logic [3:0] master_selects_out_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_taken;
      bus_strobe_in && !bus_acknowledge_out;
   endsequence
   sequence s_ack_pulse;
      bus_acknowledge_out ##1 !bus_acknowledge_out;
   endsequence
   property p_bus_handshake;
      s_taken |=> s_ack_pulse;
   endproperty
   property p_ack_cause;
      bus_acknowledge_out |-> $past(bus_strobe_in) && !$past(bus_acknowledge_out);
   endproperty
   // Read data may move only in the acknowledge cycle of a read
   property p_read_hold;
      $changed(bus_read_data) |-> bus_acknowledge_out && !$past(bus_write_not_read);
   endproperty
   property p_master_pins;
      serial_clock_oe == mosi_oe;
   endproperty
   property p_miso_dir;
      miso_oe |-> !serial_clock_oe;
   endproperty
   property p_miso_select;
      $rose(miso_oe) |-> !slave_select_in_n && !$past(slave_select_in_n);
   endproperty
   property p_selects_gated;
      !serial_clock_oe && !$past(serial_clock_oe) |-> master_selects_out_n == 4'hf;
   endproperty
   property p_wake_pulse;
      wakeup_out |=> !wakeup_out;
   endproperty
   property p_wake_slave;
      wakeup_out |-> !serial_clock_oe;
   endproperty
   a_bus_handshake: assert property (p_bus_handshake) else $error("ack timing");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
   a_read_hold: assert property (p_read_hold) else $error("read data moved");
   a_master_pins: assert property (p_master_pins) else $error("clock and mosi drive differ");
   a_miso_dir: assert property (p_miso_dir) else $error("miso driven in master");
   a_miso_select: assert property (p_miso_select) else $error("miso driven unselected");
   a_selects_gated: assert property (p_selects_gated) else $error("select low outside master");
   a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup too long");
   a_wake_slave: assert property (p_wake_slave) else $error("wakeup in master");
endmodule // spmc_ctrl_chk

// ===== spmc_spi_peer.sv
// Serial slave model answering the controller in master mode
`timescale 1ns/1ps
module spmc_spi_peer (
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   int n = 0;
   logic lead;
   initial miso = 1'b0;
   initial got = 8'h00;
   // Released line flips so a stale bit never passes for data
   always @(posedge sel_n) miso = ~miso;
   always @(negedge sel_n) begin
      n = cpha ? 0 : 1;
      if (!cpha) miso = lsb_first ? reply[0] : reply[7];
   end
   always @(sck) begin
      lead = (sck != cpol);
      if (!sel_n && lead != cpha) got = lsb_first ? {mosi, got[7:1]} : {got[6:0], mosi};
      if (!sel_n && lead == cpha) begin
         miso = lsb_first ? reply[n % 8] : reply[7 - n % 8];
         n++;
      end
   end
endmodule // spmc_spi_peer

// ===== spmc_ctrl_tb_top.sv
// Self-checking bench for the SPI controller
`timescale 1ns/1ps
module spmc_ctrl_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strobe = 1'b0;
   logic we = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic tb_sck = 1'b0;
   logic tb_mosi = 1'b0;
   logic tb_ssel_n = 1'b1;
   logic cpol = 1'b0;
   logic cpha = 1'b0;
   logic lsb = 1'b0;
   logic [7:0] reply = 8'h00;
   logic [7:0] rdata, peer_got;
   logic ack, irq, wake, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
   logic [3:0] mcs_n;
   wire sck_pin = sck_oe ? sck_out : tb_sck;
   wire mosi_pin = mosi_oe ? mosi_out : tb_mosi;
   wire miso_pin = miso_oe ? miso_out : peer_miso;
   int fails = 0;
   int num_checks = 0;
   int act = 0;
   int wakes = 0;
   always #5 clk = ~clk;
   // Active serial clock level is counted so the divider shows up as a figure
   always @(posedge clk) begin
      if (sck_oe === 1'b1 && sck_pin !== cpol) act <= act + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
   end
   spmc_ctrl #(.RX_DEPTH(2)) dut_u (
      .clk(clk), .rst_n(rst_n), .bus_strobe_in(strobe), .bus_write_not_read(we),
      .bus_register_address(addr), .bus_write_data(wdat), .bus_read_data(rdata),
      .bus_acknowledge_out(ack), .interrupt_request_out(irq), .wakeup_out(wake),
      .received_serial_clock(sck_pin), .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
      .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_pin),
      .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_in_n(tb_ssel_n),
      .master_selects_out_n(mcs_n)
   );
   spmc_spi_peer peer_u (
      .sck(sck_pin), .mosi(mosi_pin), .sel_n(mcs_n[0]), .cpol(cpol), .cpha(cpha),
      .lsb_first(lsb), .reply(reply), .miso(peer_miso), .got(peer_got)
   );
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Strobe drops at the acknowledge edge; one idle edge then separates calls
   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n = 0;
      strobe <= 1'b1;
      we <= wr_en;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      q = rdata;
      strobe <= 1'b0;
      @(posedge clk);
      if (n >= 20) fails++;
      if (n >= 20) test_done();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic poll(input int b);
      logic [7:0] q = 8'h00;
      int n = 0;
      while (q[b] !== 1'b1 && n < 100) begin
         bus(1'b0, spmc_pkg::ADDR_STATUS, 8'h00, q);
         n++;
      end
      if (q[b] !== 1'b1) fails++;
      if (q[b] !== 1'b1) test_done();
   endtask
   task automatic t_reset;
      chk({4'h0, mcs_n}, 8'h0f);
      chk({6'h0, sck_oe, miso_oe}, 8'h00);
      rd_chk(spmc_pkg::ADDR_CTRL_TWO, spmc_pkg::CTRL_TWO_RESET);
      rd_chk(spmc_pkg::ADDR_CLK_DIV, spmc_pkg::CLK_DIV_RESET);
      rd_chk(spmc_pkg::ADDR_CS_CTRL, spmc_pkg::CS_CTRL_RESET);
      wr(spmc_pkg::ADDR_UNMAPPED_DATA, 8'h5a);
      rd_chk(spmc_pkg::ADDR_UNMAPPED_DATA, 8'h00);
      $display("reset test ended");
   endtask
   task automatic t_master;
      int a0;
      for (int i = 0; i < 8; i++) begin
         cpol <= i[2];
         cpha <= i[1];
         lsb <= i[0];
         reply <= 8'h3c ^ 8'(i * 17);
         wr(spmc_pkg::ADDR_CLK_DIV, 8'(2 + i % 3));
         wr(spmc_pkg::ADDR_CTRL_TWO, {5'h10, i[2:0]});
         wr(spmc_pkg::ADDR_CS_CTRL, 8'hf1);
         chk({4'h0, mcs_n}, 8'h0e);
         chk({7'h0, sck_pin}, {7'h0, i[2]});
         a0 = act;
         wr(spmc_pkg::ADDR_TX_DATA, 8'ha5 + 8'(i));
         poll(spmc_pkg::FLAG_RX_READY);
         rd_chk(spmc_pkg::ADDR_RX_DATA, reply);
         chk(peer_got, 8'ha5 + 8'(i));
         chk(8'(act - a0), 8'(8 * (2 + i % 3 - (2 + i % 3) / 2)));
         wr(spmc_pkg::ADDR_CS_CTRL, 8'hf0);
      end
      rd_chk(spmc_pkg::ADDR_IRQ_FLAGS, 8'h03);
      wr(spmc_pkg::ADDR_IRQ_FLAGS, 8'h03);
      rd_chk(spmc_pkg::ADDR_IRQ_FLAGS, 8'h00);
      $display("master test ended");
   endtask
   task automatic t_fault;
      tb_ssel_n <= 1'b0;
      repeat (6) @(posedge clk);
      tb_ssel_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      rd_chk(spmc_pkg::ADDR_IRQ_FLAGS, 8'h04);
      wr(spmc_pkg::ADDR_IRQ_EN, 8'h04);
      chk({7'h0, irq}, 8'h01);
      wr(spmc_pkg::ADDR_IRQ_FLAGS, 8'h04);
      @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      $display("fault test ended");
   endtask
   task automatic ext_byte(input logic [7:0] b, input logic [7:0] exp);
      logic [7:0] r;
      for (int k = 7; k >= 0; k--) begin
         tb_mosi <= b[k];
         repeat (8) @(posedge clk);
         tb_sck <= 1'b1;
         r[k] = miso_pin;
         repeat (8) @(posedge clk);
         tb_sck <= 1'b0;
      end
      chk(r, exp);
   endtask
   task automatic t_slave;
      int w0 = wakes;
      wr(spmc_pkg::ADDR_CTRL_TWO, 8'h00);
      wr(spmc_pkg::ADDR_CTRL_ONE, 8'h80);
      wr(spmc_pkg::ADDR_IRQ_EN, 8'h08);
      wr(spmc_pkg::ADDR_TX_DATA, 8'h96);
      tb_ssel_n <= 1'b0;
      for (int j = 0; j < 3; j++) ext_byte(8'h11 * 8'(j + 1), j == 0 ? 8'h96 : spmc_pkg::SLAVE_IDLE_BYTE);
      repeat (8) @(posedge clk);
      tb_ssel_n <= 1'b1;
      tb_mosi <= ~tb_mosi;
      repeat (4) @(posedge clk);
      chk(8'(wakes - w0), 8'h01);
      chk({7'h0, irq}, 8'h01);
      rd_chk(spmc_pkg::ADDR_IRQ_FLAGS, 8'h0b);
      rd_chk(spmc_pkg::ADDR_RX_DATA, 8'h11);
      rd_chk(spmc_pkg::ADDR_RX_DATA, 8'h22);
      wr(spmc_pkg::ADDR_IRQ_FLAGS, 8'h0f);
      chk({7'h0, irq}, 8'h00);
      wr(spmc_pkg::ADDR_CTRL_ONE, 8'h00);
      wr(spmc_pkg::ADDR_CTRL_TWO, 8'h40);
      tb_ssel_n <= 1'b0;
      ext_byte(8'h44, spmc_pkg::HANDSHAKE_WAIT_BYTE);
      repeat (8) @(posedge clk);
      tb_ssel_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(8'(wakes - w0), 8'h01);
      rd_chk(spmc_pkg::ADDR_RX_DATA, 8'h44);
      $display("slave test ended");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Bus logic is left alone for 1us after reset release
      repeat (100) @(posedge clk);
      t_reset();
      t_master();
      t_fault();
      t_slave();
      test_done();
   end
endmodule // spmc_ctrl_tb_top
bind spmc_ctrl spmc_ctrl_chk chk_u (
   .clk(clk), .rst_n(rst_n), .bus_strobe_in(bus_strobe_in), .bus_write_not_read(bus_write_not_read),
   .bus_read_data(bus_read_data), .bus_acknowledge_out(bus_acknowledge_out), .wakeup_out(wakeup_out),
   .serial_clock_oe(serial_clock_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
   .slave_select_in_n(slave_select_in_n), .master_selects_out_n(master_selects_out_n)
);
